/* File: design/rfect_edge_detect.sv */
module rfect_edge_detect
  import rfect_pkg::*;
#(
  parameter int WIDTH = 4
)(
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  // asynchronous levels
  input  wire logic [WIDTH-1:0] level_in,
  // synchronised level and edges
  output logic      [WIDTH-1:0] level_out,
  output logic      [WIDTH-1:0] rise_out,
  output logic      [WIDTH-1:0] fall_out
);
  if (WIDTH < 1)
  begin : g_bad_width
    $error("rfect_edge_detect: WIDTH must be positive");
  end

  // ==========================================================================
  // two-flop synchroniser, then a third stage for edges
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= level_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~prev_q;
  assign fall_out  = ~sync_q & prev_q;
endmodule // rfect_edge_detect

/* File: design/rfect_pkg.sv */
package rfect_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0]  RFECT_OFF_CONFIG    = 8'h10;
  localparam logic [7:0]  RFECT_OFF_PRESET    = 8'h14;
  localparam logic [7:0]  RFECT_OFF_COUNT     = 8'h18;
  localparam logic [7:0]  RFECT_OFF_IRQ_STAT  = 8'h1c;
  localparam logic [7:0]  RFECT_OFF_IRQ_EN    = 8'h20;
  localparam logic [7:0]  RFECT_OFF_IRQ_CLR   = 8'h24;
  localparam logic [31:0] RFECT_CONFIG_RESET  = 32'h0000_0000;
  localparam logic [31:0] RFECT_PRESET_RESET  = 32'h0000_0000;
  localparam logic [31:0] RFECT_CONFIG_MASK   = 32'h001f_ffff;

  // ==========================================================================
  // configuration field positions
  localparam int RFECT_B_HALT_RX_BEGIN  = 20;
  localparam int RFECT_B_HALT_TX_BEGIN  = 19;
  localparam int RFECT_B_HALT_EXT_SEEN  = 18;
  localparam int RFECT_B_HALT_EXT_LOST  = 17;
  localparam int RFECT_B_HALT_OWN_ON    = 16;
  localparam int RFECT_B_HALT_OWN_OFF   = 15;
  localparam int RFECT_B_RUN_RX_BEGIN   = 14;
  localparam int RFECT_B_RUN_RX_END     = 13;
  localparam int RFECT_B_RUN_TX_BEGIN   = 12;
  localparam int RFECT_B_RUN_TX_END     = 11;
  localparam int RFECT_B_RUN_EXT_SEEN   = 10;
  localparam int RFECT_B_RUN_EXT_LOST   = 9;
  localparam int RFECT_B_RUN_OWN_ON     = 8;
  localparam int RFECT_B_RUN_OWN_OFF    = 7;
  localparam int RFECT_B_RUN_NOW        = 6;
  localparam int RFECT_B_RATE_HI        = 5;
  localparam int RFECT_B_RATE_LO        = 3;
  localparam int RFECT_B_PRESCALER_USE  = 2;
  localparam int RFECT_B_AUTO_RELOAD    = 1;
  localparam int RFECT_B_MASTER_ENABLE  = 0;

  // ==========================================================================
  // event numbering and timing
  localparam int RFECT_NUM_EVENTS       = 8;
  localparam int RFECT_RX_NIBBLE_BITS   = 4;
  // rf interface clock 13.56 MHz is modelled as a tick every cycle of the host clock
  localparam int RFECT_BASE_DIV         = 1;

  typedef enum logic [1:0] {
    RFECT_ST_IDLE    = 2'b00,
    RFECT_ST_RUN     = 2'b01,
    RFECT_ST_EXPIRED = 2'b10
  } rfect_state_e;

endpackage

/* File: design/rfect_prescaler.sv */
module rfect_prescaler
  import rfect_pkg::*;
#(
  parameter int STAGES = 8
)(
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // control
  input  wire logic       run_in,
  input  wire logic       use_prescaler_in,
  input  wire logic [2:0] rate_sel_in,
  // tick out
  output logic            tick_out
);
  // the rate select picks one of eight divider taps, so no other depth can serve it
  if (STAGES != 8)
  begin : g_bad_stages
    $error("rfect_prescaler: STAGES must be 8");
  end

  // ==========================================================================
  // binary ripple divider: bit k toggles at base/2^(k+1)
  logic [STAGES-1:0] div_q;
  logic [STAGES-1:0] div_d;
  logic [STAGES-1:0] rise;
  logic              tick_d;

  assign div_d = run_in ? div_q + 8'h01 : 8'h00;

  // a tick marks the carry into bit k+1, i.e. all lower bits set
  genvar k;
  generate
    for (k = 0; k < STAGES; k++)
    begin : g_rise
      assign rise[k] = run_in && (&div_q[k:0]);
    end
  endgenerate

  assign tick_d = run_in && (use_prescaler_in ? rise[rate_sel_in] : 1'b1); // [RQ11] [RQ12]

  // divider restarts with the timer so the first tick has a full period
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      div_q    <= 8'h00;
      tick_out <= 1'b0;
    end
    else
    begin
      div_q    <= div_d;
      tick_out <= tick_d;
    end
  end
endmodule // rfect_prescaler

/* File: design/rfect_timer.sv */
// Overview of operation
// [RQ1] halt bit 20: stop once reception began and four bits arrived
// [RQ2] halt bit 19: stop when a transmission begins
// [RQ3] halt bit 18: stop when an external field is detected
// [RQ4] halt bit 17: stop when the external field vanishes
// [RQ5] halt bits 16/15: stop when own field turns on/off
// [RQ6] run bits 14/13: start on first received bit / reception end
// [RQ7] run bits 12/11: start on transmission begin / end
// [RQ8] run bits 10/9: start when external field appears / vanishes
// [RQ9] run bits 8/7: start when own field turns on / off
// [RQ10] run bit 6: start immediately on software write
// [RQ11] rate field 5:3 picks 6.78 MHz down to 53 kHz
// [RQ12] bit 2 selects rf interface clock or prescaled rate
// [RQ13] reload clear: halt on expiry with count held at zero
// [RQ14] reload set: reload preset on expiry and keep counting
// [RQ15] bit 0 enables timer; when clear nothing starts it
// [RQ16] decrement once per tick; zero raises sticky expiry flag
// [RQ17] configuration resets to all zero
//
// Decided for this implementation: the strobed register port.
module rfect_timer
  import rfect_pkg::*;
#(
  parameter int CNT_W = 20
)(
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  // register port
  input  wire logic [7:0]       reg_addr_in,
  input  wire logic [31:0]      reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  output logic      [31:0]      reg_rdata_out,
  // rf and protocol levels, asynchronous to the system clock
  input  wire logic             rx_active_in,
  input  wire logic             tx_active_in,
  input  wire logic             ext_field_in,
  input  wire logic             own_field_in,
  // receiver bit strobe, same clock domain
  input  wire logic             rx_bit_in,
  // status
  output logic                  running_out,
  output logic                  expired_out,
  output logic                  irq_out
);
  if (CNT_W < 1 || CNT_W > 32)
  begin : g_bad_cnt_w
    $error("rfect_timer: CNT_W must be 1..32");
  end

  // ==========================================================================
  // register decode
  logic        wr_config;
  logic        wr_preset;
  logic        wr_irq_en;
  logic        wr_irq_clr;
  logic        rd_hit;
  logic [31:0] rd_mux;

  assign wr_config  = reg_wr_in && (reg_addr_in == RFECT_OFF_CONFIG);
  assign wr_preset  = reg_wr_in && (reg_addr_in == RFECT_OFF_PRESET);
  assign wr_irq_en  = reg_wr_in && (reg_addr_in == RFECT_OFF_IRQ_EN);
  assign wr_irq_clr = reg_wr_in && (reg_addr_in == RFECT_OFF_IRQ_CLR);

  // ==========================================================================
  // registers
  logic [31:0]      config_q;
  logic [CNT_W-1:0] preset_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             irq_stat_q;
  logic             irq_en_q;
  logic             now_pulse_q;
  rfect_state_e     state_q;
  rfect_state_e     state_d;

  // configuration register; the immediate-start bit also fires a one-shot pulse
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      config_q    <= RFECT_CONFIG_RESET; // [RQ17]
      preset_q    <= RFECT_PRESET_RESET[CNT_W-1:0];
      irq_en_q    <= 1'b0;
      now_pulse_q <= 1'b0;
    end
    else
    begin
      if (wr_config)
        config_q <= reg_wdata_in & RFECT_CONFIG_MASK;
      if (wr_preset)
        preset_q <= reg_wdata_in[CNT_W-1:0];
      if (wr_irq_en)
        irq_en_q <= reg_wdata_in[0];
      now_pulse_q <= wr_config && reg_wdata_in[RFECT_B_RUN_NOW]; // [RQ10]
    end
  end

  // ==========================================================================
  // event detection
  logic [3:0] lvl;
  logic [3:0] rise;
  logic [3:0] fall;

  rfect_edge_detect #(
    .WIDTH (4)
  ) u_edges (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .level_in   ({own_field_in, ext_field_in, tx_active_in, rx_active_in}),
    .level_out  (lvl),
    .rise_out   (rise),
    .fall_out   (fall)
  );

  // count received bits of a reception so the halt fires after the fourth
  logic [2:0] rx_bits_q;
  logic       rx_first_bit;
  logic       rx_nibble;

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      rx_bits_q <= 3'h0;
    else if (!lvl[0])
      rx_bits_q <= 3'h0;
    else if (rx_bit_in && rx_bits_q != RFECT_RX_NIBBLE_BITS[2:0])
      rx_bits_q <= rx_bits_q + 3'h1;
  end

  assign rx_first_bit = lvl[0] && rx_bit_in && (rx_bits_q == 3'h0);
  assign rx_nibble    = lvl[0] && rx_bit_in &&
                        (rx_bits_q == RFECT_RX_NIBBLE_BITS[2:0] - 3'h1);

  // ==========================================================================
  // start and halt trigger groups
  logic halt_ev;
  logic run_ev;
  logic [31:0] c;

  assign c = config_q;

  assign halt_ev = (c[RFECT_B_HALT_RX_BEGIN] && rx_nibble) ||  // [RQ1]
                   (c[RFECT_B_HALT_TX_BEGIN] && rise[1])   ||  // [RQ2]
                   (c[RFECT_B_HALT_EXT_SEEN] && rise[2])   ||  // [RQ3]
                   (c[RFECT_B_HALT_EXT_LOST] && fall[2])   ||  // [RQ4]
                   (c[RFECT_B_HALT_OWN_ON]   && rise[3])   ||  // [RQ5]
                   (c[RFECT_B_HALT_OWN_OFF]  && fall[3]);      // [RQ5]

  assign run_ev  = c[RFECT_B_MASTER_ENABLE] && (               // [RQ15]
                   (c[RFECT_B_RUN_RX_BEGIN] && rx_first_bit) || // [RQ6]
                   (c[RFECT_B_RUN_RX_END]   && fall[0])      || // [RQ6]
                   (c[RFECT_B_RUN_TX_BEGIN] && rise[1])      || // [RQ7]
                   (c[RFECT_B_RUN_TX_END]   && fall[1])      || // [RQ7]
                   (c[RFECT_B_RUN_EXT_SEEN] && rise[2])      || // [RQ8]
                   (c[RFECT_B_RUN_EXT_LOST] && fall[2])      || // [RQ8]
                   (c[RFECT_B_RUN_OWN_ON]   && rise[3])      || // [RQ9]
                   (c[RFECT_B_RUN_OWN_OFF]  && fall[3])      || // [RQ9]
                   now_pulse_q);                                // [RQ10]

  // ==========================================================================
  // count tick
  logic tick;

  rfect_prescaler #(
    .STAGES (8)
  ) u_prescaler (
    .sys_clk_in       (sys_clk_in),
    .rst_in           (rst_in),
    .run_in           (state_q == RFECT_ST_RUN),
    .use_prescaler_in (c[RFECT_B_PRESCALER_USE]),
    .rate_sel_in      (c[RFECT_B_RATE_HI:RFECT_B_RATE_LO]),
    .tick_out         (tick)
  );

  // ==========================================================================
  // counter state machine; a halt wins over a start in the same cycle
  logic expire;

  assign expire = (state_q == RFECT_ST_RUN) && tick && (count_q == '0);

  always_comb
  begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      RFECT_ST_IDLE, RFECT_ST_EXPIRED:
      begin
        if (run_ev && !halt_ev)
        begin
          state_d = RFECT_ST_RUN;
          count_d = preset_q;
        end
      end
      RFECT_ST_RUN:
      begin
        if (halt_ev || !c[RFECT_B_MASTER_ENABLE])
          state_d = RFECT_ST_IDLE;
        else if (expire && c[RFECT_B_AUTO_RELOAD])
          count_d = preset_q;                                   // [RQ14]
        else if (expire)
        begin
          state_d = RFECT_ST_EXPIRED;                           // [RQ13]
          count_d = '0;
        end
        else if (tick)
          count_d = count_q - 1'b1;                             // [RQ16]
      end
      default:
        state_d = RFECT_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_q <= RFECT_ST_IDLE;
      count_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  // sticky expiry flag: a new expiry beats a clear in the same cycle
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      irq_stat_q <= 1'b0;
    else if (expire)
      irq_stat_q <= 1'b1;                                       // [RQ16]
    else if (wr_irq_clr && reg_wdata_in[0])
      irq_stat_q <= 1'b0;
  end

  // ==========================================================================
  // read data and status outputs, all registered
  assign rd_hit = (reg_addr_in == RFECT_OFF_CONFIG)   || (reg_addr_in == RFECT_OFF_PRESET) ||
                  (reg_addr_in == RFECT_OFF_COUNT)    || (reg_addr_in == RFECT_OFF_IRQ_STAT) ||
                  (reg_addr_in == RFECT_OFF_IRQ_EN);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (reg_addr_in == RFECT_OFF_CONFIG)
      rd_mux = config_q;
    else if (reg_addr_in == RFECT_OFF_PRESET)
      rd_mux[CNT_W-1:0] = preset_q;
    else if (reg_addr_in == RFECT_OFF_COUNT)
      rd_mux[CNT_W-1:0] = count_q;
    else if (reg_addr_in == RFECT_OFF_IRQ_STAT)
      rd_mux[0] = irq_stat_q;
    else if (reg_addr_in == RFECT_OFF_IRQ_EN)
      rd_mux[0] = irq_en_q;
  end

  // unmapped or write-only addresses read zero
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      reg_rdata_out <= 32'h0000_0000;
      running_out   <= 1'b0;
      expired_out   <= 1'b0;
      irq_out       <= 1'b0;
    end
    else
    begin
      reg_rdata_out <= (reg_rd_in && rd_hit) ? rd_mux : 32'h0000_0000;
      running_out   <= (state_d == RFECT_ST_RUN);
      expired_out   <= (state_d == RFECT_ST_EXPIRED);
      irq_out       <= irq_en_q && (irq_stat_q || expire);
    end
  end

  // ==========================================================================
  // assertions
  a_config_reset_zero: assert property (@(posedge sys_clk_in) // [RQ17]
    $past(rst_in) |-> config_q == 32'h0000_0000)
    else $error("config not zero after reset");

  a_disabled_no_run: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ15]
    (state_q != RFECT_ST_RUN && !c[RFECT_B_MASTER_ENABLE]) |=> state_q != RFECT_ST_RUN)
    else $error("timer started while disabled");

  a_now_starts: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ10]
    (now_pulse_q && c[RFECT_B_MASTER_ENABLE] && !halt_ev) |=> state_q == RFECT_ST_RUN)
    else $error("immediate start ignored");

  a_halt_stops: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ2]
    (state_q == RFECT_ST_RUN && halt_ev) |=> state_q == RFECT_ST_IDLE)
    else $error("halt event did not stop timer");

  a_ext_seen_halt: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ3]
    (state_q == RFECT_ST_RUN && c[RFECT_B_HALT_EXT_SEEN] && rise[2]) |=> !running_out)
    else $error("external field did not stop timer");

  a_tick_decrements: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ16]
    (state_q == RFECT_ST_RUN && tick && count_q != '0 && !halt_ev && c[0])
      |=> count_q == $past(count_q) - 1'b1)
    else $error("count did not decrement");

  a_expire_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ13]
    (expire && !c[RFECT_B_AUTO_RELOAD] && !halt_ev && c[0])
      |=> (state_q == RFECT_ST_EXPIRED && count_q == '0))
    else $error("expiry did not halt at zero");

  a_expire_reload: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ14]
    (expire && c[RFECT_B_AUTO_RELOAD] && !halt_ev && c[0])
      |=> (state_q == RFECT_ST_RUN && count_q == $past(preset_q)))
    else $error("expiry did not reload");

  a_unprescaled_tick: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ12]
    (state_q == RFECT_ST_RUN && $past(state_q) == RFECT_ST_RUN && !c[RFECT_B_PRESCALER_USE]
      && $stable(c)) |-> tick)
    else $error("no tick at base rate");

  a_flag_sticky: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ16]
    expire |=> irq_stat_q)
    else $error("expiry flag not set");

  a_nibble_halts: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ1]
    (state_q == RFECT_ST_RUN && c[RFECT_B_HALT_RX_BEGIN] && rx_nibble) |=> !running_out)
    else $error("fourth received bit did not stop timer");

  a_own_on_starts: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ9]
    (state_q == RFECT_ST_IDLE && c[RFECT_B_MASTER_ENABLE] && c[RFECT_B_RUN_OWN_ON] && rise[3]
      && !halt_ev) |=> running_out)
    else $error("own field on did not start timer");

  a_irq_level: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RQ16]
    (irq_en_q && irq_stat_q) |=> irq_out)
    else $error("enabled expiry flag did not raise interrupt");

  c_start_run: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    state_q == RFECT_ST_IDLE ##1 state_q == RFECT_ST_RUN);
  c_expire_hold: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    state_q == RFECT_ST_EXPIRED);
  c_reload: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    expire && c[RFECT_B_AUTO_RELOAD]);
  c_rx_halt: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    state_q == RFECT_ST_RUN && rx_nibble && c[RFECT_B_HALT_RX_BEGIN]);
endmodule // rfect_timer

/* File: tb/rfect_timer_bench.sv */
module rfect_timer_bench
  import rfect_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // signals
  logic        sys_clk_in;
  logic        rst_in;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] rdata;
  logic        rx_bit;
  logic [3:0]  lv;          // rx, tx, ext, own levels
  logic        running;
  logic        expired;
  logic        irq;
  int          fails;
  int          check_count;
  int          cycles;
  int          seed;
  int          m;
  int          n_pre;
  logic [31:0] d;
  logic [31:0] r;
  logic [7:0]  al [6];

  rfect_timer #(.CNT_W(20)) rfect_timer_inst (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .reg_addr_in   (reg_addr),
    .reg_wdata_in  (reg_wdata),
    .reg_wr_in     (reg_wr),
    .reg_rd_in     (reg_rd),
    .reg_rdata_out (rdata),
    .rx_active_in  (lv[0]),
    .tx_active_in  (lv[1]),
    .ext_field_in  (lv[2]),
    .own_field_in  (lv[3]),
    .rx_bit_in     (rx_bit),
    .running_out   (running),
    .expired_out   (expired),
    .irq_out       (irq)
  );

  // ==========================================================================
  // clock and hang guard
  initial
  begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // whole run needs far fewer cycles; a stuck wait ends here
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      complete_run();
    end
  end

  // ==========================================================================
  // tasks and helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_in);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk_in);
    reg_wr    <= 1'b0;
  endtask

  // read data is only valid in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_in);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk_in);
    reg_rd   <= 1'b0;
    @(negedge sys_clk_in);
    v = rdata;
  endtask

  task automatic setpin(input int p, input logic v);
    @(posedge sys_clk_in);
    lv[p] <= v;
  endtask

  task automatic pulse;
    @(posedge sys_clk_in);
    rx_bit <= 1'b1;
    @(posedge sys_clk_in);
    rx_bit <= 1'b0;
  endtask

  // cycles from entering run until the expired output shows
  task automatic wait_exp(output int n);
    int k;
    n = 0;
    k = 0;
    while (running !== 1'b1 && k < 20)
    begin
      @(negedge sys_clk_in);
      k++;
    end
    while (expired !== 1'b1 && n < 3000)
    begin
      @(negedge sys_clk_in);
      n++;
    end
  endtask

  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return {31'h0, (v >= lo && v <= hi)};
  endfunction

  function automatic int pin_of(input int b);
    case (b)
      13:             return 0;
      19, 12, 11:     return 1;
      18, 17, 10, 9:  return 2;
      default:        return 3;
    endcase
  endfunction

  // halt bits start running at once and must stop; run bits must start
  task automatic ev_test(input int b);
    logic h;
    logic rs;
    int   p;
    h  = (b >= 15);
    rs = b inside {19, 18, 16, 12, 10, 8};
    p  = pin_of(b);
    setpin(p, !rs);
    cyc(6);
    wr(RFECT_OFF_CONFIG, (32'h1 << b) | 32'h3 | (h ? 32'h40 : 32'h0));
    cyc(4);
    chk({31'h0, running}, {31'h0, h});
    setpin(p, rs);
    cyc(6);
    chk({31'h0, running}, {31'h0, !h});
    wr(RFECT_OFF_CONFIG, 32'h0);
    cyc(2);
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    rst_in    = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    rx_bit    = 1'b0;
    lv        = 4'h0;
    seed      = 74961;
    al        = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h3c};
    cyc(5);
    rst_in <= 1'b0;
    foreach (al[i])
    begin
      rd(al[i], d);
      chk(d, 32'h0);
    end
    $display("test done: reset values");
    // random configs with the master enable off: stored masked, never run
    repeat (4)
    begin
      r    = $random(seed);
      r[0] = 1'b0;
      r[6] = 1'b1;
      wr(RFECT_OFF_CONFIG, r);
      rd(RFECT_OFF_CONFIG, d);
      chk(d, r & RFECT_CONFIG_MASK);
      chk({31'h0, running}, 32'h0);
    end
    $display("test done: config storage");
    n_pre = 3 + int'($unsigned($random(seed)) % 32);
    wr(RFECT_OFF_PRESET, n_pre);
    wr(RFECT_OFF_CONFIG, 32'h41);
    wait_exp(m);
    chk(inr(m, n_pre, n_pre + 3), 32'h1);
    cyc(3);
    rd(RFECT_OFF_COUNT, d);
    chk(d, 32'h0);
    chk({31'h0, running}, 32'h0);
    rd(RFECT_OFF_IRQ_STAT, d);
    chk(d, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(RFECT_OFF_IRQ_EN, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(RFECT_OFF_IRQ_CLR, 32'h1);
    cyc(2);
    rd(RFECT_OFF_IRQ_STAT, d);
    chk(d, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test done: one shot and interrupt");
    wr(RFECT_OFF_CONFIG, 32'h43);
    cyc(4 * (n_pre + 1));
    chk({31'h0, running}, 32'h1);
    chk({31'h0, expired}, 32'h0);
    rd(RFECT_OFF_IRQ_STAT, d);
    chk(d, 32'h1);
    wr(RFECT_OFF_CONFIG, 32'h2);
    cyc(3);
    chk({31'h0, running}, 32'h0);
    wr(RFECT_OFF_IRQ_CLR, 32'h1);
    wr(RFECT_OFF_IRQ_EN, 32'h0);
    $display("test done: reload");
    // preset 2 takes three ticks, each 2^(sel+1) cycles long
    for (int s = 0; s < 8; s++)
    begin
      wr(RFECT_OFF_PRESET, 32'h2);
      wr(RFECT_OFF_CONFIG, 32'h45 | (s << 3));
      wait_exp(m);
      chk(inr(m, 3 * (2 << s) - 2, 3 * (2 << s) + 3), 32'h1);
    end
    $display("test done: prescaler");
    wr(RFECT_OFF_PRESET, 32'h3e8);
    for (int b = 7; b < 20; b++)
      if (b != 14)
        ev_test(b);
    setpin(1, 1'b0);
    cyc(6);
    wr(RFECT_OFF_CONFIG, 32'h1002);
    setpin(1, 1'b1);
    cyc(6);
    chk({31'h0, running}, 32'h0);
    setpin(0, 1'b1);
    cyc(6);
    wr(RFECT_OFF_CONFIG, (32'h1 << 14) | 32'h3);
    cyc(4);
    chk({31'h0, running}, 32'h0);
    pulse();
    cyc(4);
    chk({31'h0, running}, 32'h1);
    wr(RFECT_OFF_CONFIG, 32'h0);
    setpin(0, 1'b0);
    cyc(6);
    wr(RFECT_OFF_CONFIG, (32'h1 << 20) | 32'h43);
    setpin(0, 1'b1);
    cyc(6);
    repeat (3) pulse();
    cyc(3);
    chk({31'h0, running}, 32'h1);
    pulse();
    cyc(4);
    chk({31'h0, running}, 32'h0);
    $display("test done: trigger events");
    complete_run();
  end

endmodule // rfect_timer_bench
